// [rbu_pkg.sv]
// Package for the relative branch unit: opcodes, widths, phase and state types
package rbu_pkg;
  localparam int unsigned PC_W = 21;
  localparam int unsigned OP_W = 16;
  localparam logic [7:0] OPC_JUMP_IF_NEGATIVE     = 8'he6;
  localparam logic [7:0] OPC_JUMP_IF_NO_CARRY     = 8'he3;
  localparam logic [7:0] OPC_JUMP_IF_NON_NEGATIVE = 8'he7;
  localparam logic [7:0] OPC_JUMP_IF_NO_OVERFLOW  = 8'he5;
  localparam logic [7:0] OPC_JUMP_IF_NONZERO      = 8'he1;
  localparam logic [4:0] OPC_UNCONDITIONAL_JUMP_REL = 5'h1a;
  localparam logic [PC_W-1:0] PC_STEP = 21'h000002;
  localparam logic [PC_W-1:0] PC_RESET = 21'h000000;

  // Four phases of one instruction cycle
  typedef enum logic [1:0] {
    RBU_Q1,
    RBU_Q2,
    RBU_Q3,
    RBU_Q4
  } rbu_phase_t;

  // Instruction cycle kind
  typedef enum logic [0:0] {
    RBU_EXEC,
    RBU_FLUSH
  } rbu_state_t;

  // Status flags seen by the unit
  typedef struct packed {
    logic negative;
    logic overflow;
    logic zero;
    logic carry;
  } rbu_flags_t;

  // Decode result for one opcode
  typedef struct packed {
    logic            is_jump;
    logic            taken;
    logic [PC_W-1:0] byte_offset;
  } rbu_decode_t;
endpackage

// [rbu_decoder.sv]
// Combinational opcode decoder and condition check for relative jumps
`timescale 1ns/1ps
module rbu_decoder #(
  parameter int unsigned PC_W = rbu_pkg::PC_W
) (
  input  wire logic [rbu_pkg::OP_W-1:0] opcode_in,
  input  wire rbu_pkg::rbu_flags_t      flags_in,
  output rbu_pkg::rbu_decode_t          decode_out
);
  // Sign-extend and double a short or long offset field
  function automatic logic [PC_W-1:0] scaled(input logic [10:0] off, input logic wide);
    logic [PC_W-1:0] ext;
    if (wide) begin
      ext = {{(PC_W-11){off[10]}}, off};
    end else begin
      ext = {{(PC_W-8){off[7]}}, off[7:0]};
    end
    return {ext[PC_W-2:0], 1'b0};
  endfunction

  // Condition table for each opcode
  always_comb begin
    decode_out = '0;
    if (opcode_in[15:11] == rbu_pkg::OPC_UNCONDITIONAL_JUMP_REL) begin
      decode_out.is_jump = 1'b1;
      decode_out.taken = 1'b1;
      decode_out.byte_offset = scaled(opcode_in[10:0], 1'b1);
    end else begin
      decode_out.byte_offset = scaled(opcode_in[10:0], 1'b0);
      case (opcode_in[15:8])
        rbu_pkg::OPC_JUMP_IF_NEGATIVE: begin
          decode_out.is_jump = 1'b1;
          decode_out.taken = flags_in.negative;
        end
        rbu_pkg::OPC_JUMP_IF_NO_CARRY: begin
          decode_out.is_jump = 1'b1;
          decode_out.taken = ~flags_in.carry;
        end
        rbu_pkg::OPC_JUMP_IF_NON_NEGATIVE: begin
          decode_out.is_jump = 1'b1;
          decode_out.taken = ~flags_in.negative;
        end
        rbu_pkg::OPC_JUMP_IF_NO_OVERFLOW: begin
          decode_out.is_jump = 1'b1;
          decode_out.taken = ~flags_in.overflow;
        end
        rbu_pkg::OPC_JUMP_IF_NONZERO: begin
          decode_out.is_jump = 1'b1;
          decode_out.taken = ~flags_in.zero;
        end
        default: begin
          decode_out.is_jump = 1'b0;
        end
      endcase
    end
  end
endmodule

// [rbu_branch_unit.sv]
// Relative branch unit: executes the six PC-relative jumps over four phases
`timescale 1ns/1ps
module rbu_branch_unit #(
  parameter int unsigned PC_W = rbu_pkg::PC_W
) (
  input  wire logic                     ref_clk_in,
  input  wire logic                     rst_n_in,
  input  wire logic [rbu_pkg::OP_W-1:0] opcode_in,
  input  wire logic                     opcode_valid_in,
  input  wire rbu_pkg::rbu_flags_t      flags_in,
  input  wire logic [PC_W-1:0]          pc_in,
  output logic [PC_W-1:0]               pc_out,
  output logic                          pc_write_out,
  output logic                          flush_out,
  output logic                          busy_out,
  output logic                          flags_write_out,
  output rbu_pkg::rbu_phase_t           phase_out
);
  // Cycle bookkeeping and the latched decode result
  rbu_pkg::rbu_phase_t  phase;
  rbu_pkg::rbu_phase_t  next_phase;
  rbu_pkg::rbu_state_t  state;
  rbu_pkg::rbu_state_t  next_state;
  rbu_pkg::rbu_decode_t dec;
  rbu_pkg::rbu_decode_t held;
  rbu_pkg::rbu_decode_t next_held;

  // Combinational next values and edge qualifiers
  logic [PC_W-1:0]      next_pc;
  logic                 next_busy;
  logic                 next_flush;
  logic                 decode_edge;
  logic                 write_edge;
  logic                 close_edge;
  logic                 accept_jump;
  logic                 accept_taken;
  logic                 jump_ends_taken;

  // Next phase of the four-step ring; wraps from the last back to the first
  function automatic rbu_pkg::rbu_phase_t step_phase(input rbu_pkg::rbu_phase_t now);
    case (now)
      rbu_pkg::RBU_Q1: return rbu_pkg::RBU_Q2;
      rbu_pkg::RBU_Q2: return rbu_pkg::RBU_Q3;
      rbu_pkg::RBU_Q3: return rbu_pkg::RBU_Q4;
      default:         return rbu_pkg::RBU_Q1;
    endcase
  endfunction

  // True in one phase of an executing cycle; the no-operation cycle never matches
  function automatic logic exec_phase(input rbu_pkg::rbu_phase_t now,
                                      input rbu_pkg::rbu_state_t kind,
                                      input rbu_pkg::rbu_phase_t want);
    return now == want && kind == rbu_pkg::RBU_EXEC;
  endfunction

  // Decoder is purely combinational; its result only counts at the decode edge
  rbu_decoder #(
    .PC_W(PC_W)
  ) u_dec (
    .opcode_in (opcode_in),
    .flags_in  (flags_in),
    .decode_out(dec)
  );

  // Edge qualifiers: decode in Q1, write in Q3, close the cycle in Q4
  assign decode_edge = exec_phase(phase, state, rbu_pkg::RBU_Q1);
  assign write_edge  = exec_phase(phase, state, rbu_pkg::RBU_Q3);
  assign close_edge  = phase == rbu_pkg::RBU_Q4;

  // An opcode only counts when the fetch side marks the word valid
  assign accept_jump  = dec.is_jump & opcode_valid_in;
  assign accept_taken = dec.is_jump & dec.taken & opcode_valid_in;

  // A cycle that closes on a taken jump is followed by a no-operation cycle
  assign jump_ends_taken = state == rbu_pkg::RBU_EXEC && held.taken;

  // Target: pc_in already points past the jump, so only the offset is added
  assign next_pc = PC_W'(pc_in + held.byte_offset);

  // Phase advances every clock; fetch relies on it never pausing
  assign next_phase = step_phase(phase);

  // Phase counter runs continuously, one step per clock
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      phase <= rbu_pkg::RBU_Q1;
    end else begin
      phase <= next_phase;
    end
  end

  // Flags are taken at decode, so a late flag change cannot flip the outcome
  always_comb begin
    next_held = held;
    if (decode_edge) begin
      next_held.is_jump     = accept_jump;
      next_held.taken       = accept_taken;
      next_held.byte_offset = dec.byte_offset;
    end
  end

  // Decode result held for the rest of the instruction cycle
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      held <= '0;
    end else begin
      held <= next_held;
    end
  end

  // Cycle kind table: a taken jump is followed by one whole no-operation cycle
  always_comb begin
    next_state = state;
    case (state)
      rbu_pkg::RBU_EXEC: begin
        if (held.taken) begin
          next_state = rbu_pkg::RBU_FLUSH;
        end
      end
      rbu_pkg::RBU_FLUSH: begin
        next_state = rbu_pkg::RBU_EXEC;
      end
      default: begin
        next_state = rbu_pkg::RBU_EXEC;
      end
    endcase
  end

  // Cycle kind only changes at the boundary between instruction cycles
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      state <= rbu_pkg::RBU_EXEC;
    end else if (close_edge) begin
      state <= next_state;
    end
  end

  // Program counter target loads on the write edge of a taken jump and then holds
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pc_out <= rbu_pkg::PC_RESET;
    end else if (write_edge && held.taken) begin
      pc_out <= next_pc;
    end
  end

  // Write strobe is one clock wide; not-taken jumps fall through with no write
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      pc_write_out <= 1'b0;
    end else begin
      pc_write_out <= write_edge && held.taken;
    end
  end

  // Flush covers exactly the no-operation cycle after a taken jump
  always_comb begin
    next_flush = flush_out;
    if (close_edge) begin
      next_flush = jump_ends_taken;
    end
  end

  // Flush register, updated only at cycle boundaries
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      flush_out <= 1'b0;
    end else begin
      flush_out <= next_flush;
    end
  end

  // Busy rises at decode and stays up through the no-operation cycle if taken
  always_comb begin
    next_busy = busy_out;
    if (close_edge) begin
      next_busy = jump_ends_taken;
    end else if (decode_edge) begin
      next_busy = accept_jump;
    end
  end

  // Busy register; fetch uses it to know a jump is still in flight
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      busy_out <= 1'b0;
    end else begin
      busy_out <= next_busy;
    end
  end

  // Jumps never write status; held low always
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      flags_write_out <= 1'b0;
    end else begin
      flags_write_out <= 1'b0;
    end
  end

  // Phase mirrored out so the fetch logic can align with this unit
  always_ff @(posedge ref_clk_in) begin
    if (!rst_n_in) begin
      phase_out <= rbu_pkg::RBU_Q4;
    end else begin
      phase_out <= phase;
    end
  end
endmodule

// [rbu_sva.sv]
// Port checker for the relative branch unit
`timescale 1ns/1ps
module rbu_sva #(
  parameter int unsigned PC_W = rbu_pkg::PC_W
) (
  input wire logic                ref_clk_in,
  input wire logic                rst_n_in,
  input wire logic [15:0]         opcode_in,
  input wire logic                opcode_valid_in,
  input wire rbu_pkg::rbu_flags_t flags_in,
  input wire logic [PC_W-1:0]     pc_in,
  input wire logic [PC_W-1:0]     pc_out,
  input wire logic                pc_write_out,
  input wire logic                flush_out,
  input wire logic                busy_out,
  input wire logic                flags_write_out,
  input wire rbu_pkg::rbu_phase_t phase_out
);
  // Doubled offsets keep each target on the same word alignment as pc_in
  wire logic [PC_W-1:0] off_c = PC_W'(signed'({opcode_in[7:0], 1'b0}));
  wire logic [PC_W-1:0] off_u = PC_W'(signed'({opcode_in[10:0], 1'b0}));
  wire logic [7:0]      hi = opcode_in[15:8];
  wire logic            jc = hi inside {8'he6, 8'he3, 8'he7, 8'he5, 8'he1};
  wire logic            tk = hi == 8'he6 & flags_in[3] | hi == 8'he3 & !flags_in[0]
    | hi == 8'he7 & !flags_in[3] | hi == 8'he5 & !flags_in[2] | hi == 8'he1 & !flags_in[1];
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (!rst_n_in);
  // Decode edge: phase_out lags one clock, and a raised flush marks the no-operation cycle
  sequence s_take;
    phase_out == rbu_pkg::RBU_Q4 && !flush_out && opcode_valid_in;
  endsequence
  a_flags_kept: assert property (!flags_write_out) else $error("flag write");
  a_uncond_pc: assert property (s_take ##0 opcode_in[15:11] == 5'h1a |->
    ##3 pc_write_out && pc_out == $past(pc_in) + $past(off_u, 3)) else $error("bad target");
  a_cond_pc: assert property (s_take ##0 tk |->
    ##3 pc_write_out && pc_out == $past(pc_in) + $past(off_c, 3)) else $error("bad target");
  a_cond_skip: assert property (s_take ##0 jc && !tk |-> !pc_write_out [*5])
    else $error("bad jump");
  a_other_idle: assert property (s_take ##0 !jc && opcode_in[15:11] != 5'h1a
    |=> !busy_out [*4]) else $error("busy");
  a_flush_len: assert property (pc_write_out |=> flush_out [*4] ##1 !flush_out)
    else $error("flush length");
  a_pc_held: assert property ($changed(pc_out) |-> pc_write_out) else $error("pc moved");
  a_busy_flush: assert property (flush_out |-> busy_out) else $error("idle in flush");
endmodule
bind rbu_branch_unit rbu_sva #(.PC_W(PC_W)) rbu_sva_inst (.*);

// [tb.sv]
// Self-checking bench for the relative branch unit
`timescale 1ns/1ps
`define CK(a, b) begin comparisons++; if ((a) !== (b)) begin fails++; $display("Error %0t: mismatch", $time); end end
module tb;
  logic                ref_clk_in = 1'b0;
  logic                rst_n_in = 1'b0;
  logic [15:0]         opcode_in = 16'h0000;
  logic                opcode_valid_in = 1'b0;
  rbu_pkg::rbu_flags_t flags_in = 4'h0;
  logic [20:0]         pc_in = 21'h000000;
  logic [20:0]         pc_out;
  logic [20:0]         last = 21'h000000;
  logic                pc_write_out, flush_out, busy_out, flags_write_out;
  rbu_pkg::rbu_phase_t phase_out;
  logic [7:0]          kinds [7] = '{8'he6, 8'he3, 8'he7, 8'he5, 8'he1, 8'hd0, 8'h00};
  logic [15:0]         op;
  int                  fails = 0;
  int                  comparisons = 0;
  rbu_branch_unit rbu_branch_unit_inst (.ref_clk_in, .rst_n_in, .opcode_in, .opcode_valid_in,
    .flags_in, .pc_in, .pc_out, .pc_write_out, .flush_out, .busy_out, .flags_write_out, .phase_out);
  initial forever #4 ref_clk_in = ~ref_clk_in;
  task automatic close_out;
    if (fails == 0 && comparisons > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // One instruction cycle, plus the idle cycle when the jump is taken
  task automatic run(input logic [15:0] o, input logic v);
    bit j;
    bit t;
    int off;
    j = 1'b1;
    t = o[15:11] == 5'h1a;
    off = t ? $signed(o[10:0]) : $signed(o[7:0]);
    flags_in = 4'($urandom);
    pc_in = 21'($urandom);
    opcode_in = o;
    opcode_valid_in = v;
    case (o[15:8])
      8'he6: t = flags_in.negative;
      8'he3: t = !flags_in.carry;
      8'he7: t = !flags_in.negative;
      8'he5: t = !flags_in.overflow;
      8'he1: t = !flags_in.zero;
      default: j = t;
    endcase
    j = j && v;
    t = t && v;
    if (t) last = pc_in + 21'(2 * off);
    @(posedge ref_clk_in);
    // Scramble the word: it must be ignored once decoded
    #1 opcode_in = 16'($urandom);
    `CK(busy_out, j)
    `CK(phase_out, rbu_pkg::RBU_Q1)
    // Target lands two edges after decode, ahead of the closing phase
    repeat (2) @(posedge ref_clk_in);
    #1 `CK(pc_write_out, t)
    `CK(pc_out, last)
    `CK(flags_write_out, 1'b0)
    @(posedge ref_clk_in);
    #1 `CK(flush_out, t)
    `CK(busy_out, t)
    `CK(pc_write_out, 1'b0)
    if (t) begin
      repeat (4) @(posedge ref_clk_in);
      #1 `CK(flush_out, 1'b0)
      `CK(busy_out, 1'b0)
    end
  endtask
  // All six jumps and a non-jump in turn, with the most negative short offset now and then
  initial begin
    void'($urandom(32'h25e9));
    repeat (6) @(posedge ref_clk_in);
    #1 rst_n_in = 1'b1;
    for (int i = 0; i < 140; i++) begin
      op = {kinds[i % 7], 8'($urandom)};
      if (i % 7 > 4) op[10:8] = 3'($urandom);
      if (i % 9 == 0) op[7:0] = 8'h80;
      run(op, i % 11 != 3);
    end
    close_out();
  end
endmodule
